/* rtl/fcsn_glitchless_mux.sv */
// One switchable clock multiplexer with glitch-free handover and gate.
// Assumes source clocks are oversampled by the reference clock.
`timescale 1ns/10ps
`default_nettype none
module fcsn_glitchless_mux
   import fcsn_pkg::*;
(
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_rst,
   input  wire logic [MUX_INPUTS-1:0] i_src,   // Candidate clocks.
   input  wire logic [SEL_W-1:0]     i_sel,    // Requested input.
   input  wire logic                 i_en,     // Mux enable.
   output logic                      o_clk,    // Selected clock.
   output logic [SEL_W-1:0]          o_active  // Input now driving o_clk.
);
   // ==========================================================
   // Synchronise sources, select and enable into ref domain.
   logic [MUX_INPUTS-1:0] src_m, src_s, src_d; // Source sync and previous.
   logic [SEL_W-1:0]      sel_m, sel_s;        // Select sync stages.
   logic                  en_m,  en_s;         // Enable sync stages.
   logic [SEL_W-1:0]      cur;                 // Active input.
   logic                  gate;                // Output gate open.
   typedef enum logic [1:0] {FCSN_RUN, FCSN_STOP, FCSN_START} fcsn_sw_e;
   fcsn_sw_e              state;               // Handover state.
   logic [SEL_W-1:0]      tgt;                 // Input being switched to.

   // Two flops before any logic reads the pins.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         src_m <= '0; src_s <= '0; src_d <= '0;
         sel_m <= SEL_RESET; sel_s <= SEL_RESET;
         en_m  <= 1'b0; en_s <= 1'b0;
      end else begin
         src_m <= i_src; src_s <= src_m; src_d <= src_s;
         sel_m <= i_sel; sel_s <= sel_m;
         en_m  <= i_en;  en_s  <= en_m;
      end
   end

   // Handover: close on a low phase of the old clock, reopen on a low
   // phase of the new one, so no runt pulse leaves the mux.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         cur   <= SEL_RESET;
         tgt   <= SEL_RESET;
         gate  <= 1'b0;
         state <= FCSN_RUN;
      end else begin
         case (state)
            FCSN_RUN: begin
               if (en_s && sel_s != cur) begin
                  tgt   <= sel_s;
                  state <= FCSN_STOP;
               end else if (!src_s[cur]) begin
                  gate <= en_s;
               end
            end
            FCSN_STOP: begin
               if (src_d[cur] && !src_s[cur]) begin
                  gate  <= 1'b0;
                  cur   <= tgt;
                  state <= FCSN_START;
               end
            end
            FCSN_START: begin
               if (src_d[cur] && !src_s[cur]) begin
                  gate  <= en_s;
                  state <= FCSN_RUN;
               end
            end
            default: state <= FCSN_RUN;
         endcase
      end
   end

   // Output is a registered, gated copy of the active source.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) o_clk <= 1'b0;
      else       o_clk <= gate & src_s[cur];
   end

   assign o_active = cur;
endmodule : fcsn_glitchless_mux
`default_nettype wire

/* rtl/fcsn_pkg.sv */
// Package of constants for the fabric clock selection network.
// Assumes one reference clock domain; switched clocks are routed as data.
package fcsn_pkg;
   // ==========================================================
   // Sizes of the network.
   localparam int NUM_DYN_MUX     = 8;   // Switchable muxes in total.
   localparam int MUX_PER_SIDE    = 2;   // Muxes on each side.
   localparam int MUX_INPUTS      = 4;   // Inputs per switchable mux.
   localparam int SEL_W           = 2;   // Select bus width.
   localparam int NUM_GLOBAL      = 32;  // Global lines.
   localparam int NUM_REMOTE      = 16;  // Lines from fabric in other regions.
   localparam int REG_EDGE        = 8;   // Regional lines, top and bottom regions.
   localparam int REG_CORE        = 4;   // Regional lines, other regions.
   localparam int LOCAL_MAX       = 16;  // Signals one local network accepts.
   localparam int REGION_TALL     = 80;  // Core region height in cells.
   localparam int NET_TALL        = 40;  // Local network height in cells.
   localparam int IF_TB_GLOBAL    = 14;  // Top/bottom interface global clocks.
   localparam int IF_TB_FABRIC    = 2;   // Top/bottom interface fabric clocks.
   localparam int IF_SIDE_MAX     = 4;   // Side interface clocks.
   localparam int IF_SIDE_FABRIC  = 2;   // Side interface fabric clocks.
   localparam logic [1:0] SEL_RESET = 2'h0; // Input selected after reset.
   localparam int SYNC_STAGES     = 2;   // Synchroniser depth.
endpackage : fcsn_pkg

/* rtl/fcsn_top.sv */
// Top of the fabric clock selection network: eight switchable muxes,
// a core local network, interface local networks and per-cell enables.
// Assumes all clock-like inputs but i_alt_pin are sampled by the 200 MHz reference.
`timescale 1ns/10ps
`default_nettype none
module fcsn_top
   import fcsn_pkg::*;
#(
   parameter int CELLS = 80 // Cells in one column of a core region.
)(
   input  wire logic                                i_ref_clk,
   input  wire logic                                i_rst,
   input  wire logic [fcsn_pkg::NUM_DYN_MUX*fcsn_pkg::MUX_INPUTS-1:0] i_mux_src,
   input  wire logic [fcsn_pkg::NUM_DYN_MUX*fcsn_pkg::SEL_W-1:0]      i_mux_sel,
   input  wire logic [fcsn_pkg::NUM_DYN_MUX-1:0]    i_mux_en,
   output logic      [fcsn_pkg::NUM_DYN_MUX-1:0]    o_mux_clk,
   output logic      [fcsn_pkg::NUM_DYN_MUX*fcsn_pkg::SEL_W-1:0]      o_mux_active,
   input  wire logic [fcsn_pkg::NUM_REMOTE-1:0]     i_remote,
   input  wire logic [fcsn_pkg::REG_EDGE-1:0]       i_regional,
   input  wire logic                                i_edge_region,
   input  wire logic [fcsn_pkg::LOCAL_MAX*6-1:0]    i_local_sel,
   input  wire logic [1:0]                          i_local_fab,
   output logic      [fcsn_pkg::LOCAL_MAX-1:0]      o_local_lo,
   output logic      [fcsn_pkg::LOCAL_MAX-1:0]      o_local_hi,
   input  wire logic [CELLS-1:0]                    i_cell_ce,
   output logic      [CELLS-1:0]                    o_cell_ce,
   input  wire logic [fcsn_pkg::IF_TB_FABRIC-1:0]   i_if_fab,
   output logic      [fcsn_pkg::LOCAL_MAX-1:0]      o_if_tb,
   output logic      [fcsn_pkg::IF_SIDE_MAX-1:0]    o_if_side,
   input  wire logic                                i_alt_pin,
   output logic                                     o_synth_ref
);
   // ==========================================================
   // Global lines: muxes feed the first eight, rest are tied in by
   // replicating mux outputs, since only switched sources are modelled.
   logic [NUM_GLOBAL-1:0] global_line;
   logic [NUM_GLOBAL-1:0] glb_m, glb_s;  // Global sync into ref domain.

   // Eight muxes, indexed as side = i / MUX_PER_SIDE.
   for (genvar i = 0; i < NUM_DYN_MUX; i++) begin : g_mux
      fcsn_glitchless_mux u_mux (
         .i_ref_clk (i_ref_clk),
         .i_rst     (i_rst),
         .i_src     (i_mux_src[i*MUX_INPUTS +: MUX_INPUTS]),
         .i_sel     (i_mux_sel[i*SEL_W +: SEL_W]),
         .i_en      (i_mux_en[i]),
         .o_clk     (o_mux_clk[i]),
         .o_active  (o_mux_active[i*SEL_W +: SEL_W])
      );
   end

   assign global_line = {NUM_GLOBAL/NUM_DYN_MUX{o_mux_clk}};

   // ==========================================================
   // Pin-side sources pass two flops before the local pickers.
   logic [NUM_REMOTE-1:0] rem_m, rem_s;
   logic [REG_EDGE-1:0]   rg_m,  rg_s;
   logic [1:0]            fab_m, fab_s;
   logic [CELLS-1:0]      ce_m,  ce_s;
   logic                  edge_m, edge_s;
   logic [LOCAL_MAX*6-1:0] lsel_m, lsel_s; // Local picker indices, synchronised.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         glb_m <= '0; glb_s <= '0; rem_m <= '0; rem_s <= '0;
         rg_m <= '0; rg_s <= '0; fab_m <= '0; fab_s <= '0;
         ce_m <= '0; ce_s <= '0; edge_m <= 1'b0; edge_s <= 1'b0;
         lsel_m <= '0; lsel_s <= '0;
      end else begin
         glb_m <= global_line; glb_s <= glb_m;
         rem_m <= i_remote;    rem_s <= rem_m;
         rg_m  <= i_regional;  rg_s  <= rg_m;
         fab_m <= i_local_fab; fab_s <= fab_m;
         ce_m  <= i_cell_ce;   ce_s  <= ce_m;
         edge_m <= i_edge_region; edge_s <= edge_m;
         lsel_m <= i_local_sel; lsel_s <= lsel_m;
      end
   end

   // ==========================================================
   // Local pool: 32 global, 16 remote, 8 or 4 regional, 2 fabric.
   localparam int POOL = NUM_GLOBAL + NUM_REMOTE + REG_EDGE + 2;
   logic [REG_EDGE-1:0] rg_avail;
   logic [63:0]         pool;
   always_comb begin
      rg_avail = edge_s ? rg_s : {{(REG_EDGE-REG_CORE){1'b0}}, rg_s[REG_CORE-1:0]};
      pool = '0;
      pool[POOL-1:0] = {fab_s, rg_avail, rem_s, glb_s};
   end

   // Sixteen pickers per network; the two 40-cell halves share the pool
   // and the same picker indices, so both carry the same signals.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_local_lo <= '0;
         o_local_hi <= '0;
      end else begin
         for (int k = 0; k < LOCAL_MAX; k++) begin
            o_local_lo[k] <= pool[lsel_s[k*6 +: 6]];
            o_local_hi[k] <= pool[lsel_s[k*6 +: 6]];
         end
      end
   end

   // Per-cell enable from the fabric, one more flop after its two sync flops.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) o_cell_ce <= '0;
      else       o_cell_ce <= ce_s;
   end

   // ==========================================================
   // Interface regions: fixed 14 global + 2 fabric; sides 2 + 2.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_if_tb   <= '0;
         o_if_side <= '0;
      end else begin
         o_if_tb   <= {fab_s, glb_s[IF_TB_GLOBAL-1:0]};
         o_if_side <= {fab_s, rg_s[IF_SIDE_MAX-IF_SIDE_FABRIC-1:0]};
      end
   end

   // Alternate input goes straight to the synthesizer reference, not
   // through the core; no flops so the reference keeps its edges.
   assign o_synth_ref = i_alt_pin;
endmodule : fcsn_top
`default_nettype wire

/* test/fabric_clock_selection_network_bench.sv */
// Self-checking bench of the clock selection network against a behavioural model.
// Assumes the user clock model and the port checker compile alongside.
`timescale 1ns/10ps
`default_nettype none
module fabric_clock_selection_network_bench;
   import fcsn_pkg::*;
   logic        i_ref_clk, i_rst, i_edge_region, i_alt_pin, o_synth_ref;
   logic [31:0] src, seed = 32'h5E;
   logic [15:0] i_mux_sel, o_mux_active, i_remote, o_local_lo, o_local_hi, o_if_tb, ex;
   logic [7:0]  i_mux_en, o_mux_clk, i_regional, hi, lo;
   logic [95:0] i_local_sel;
   logic [79:0] i_cell_ce, o_cell_ce;
   logic [3:0]  o_if_side;
   logic [1:0]  i_local_fab, i_if_fab;
   int          num_errors = 0, cmp_count = 0, cyc = 0;
   fcsn_top fcsn_top_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_mux_src(src),
      .i_mux_sel(i_mux_sel), .i_mux_en(i_mux_en), .o_mux_clk(o_mux_clk),
      .o_mux_active(o_mux_active), .i_remote(i_remote), .i_regional(i_regional),
      .i_edge_region(i_edge_region), .i_local_sel(i_local_sel), .i_local_fab(i_local_fab),
      .o_local_lo(o_local_lo), .o_local_hi(o_local_hi), .i_cell_ce(i_cell_ce),
      .o_cell_ce(o_cell_ce), .i_if_fab(i_if_fab), .o_if_tb(o_if_tb), .o_if_side(o_if_side),
      .i_alt_pin(i_alt_pin), .o_synth_ref(o_synth_ref));
   fcsn_user_clocks fcsn_user_clocks_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .o_src(src));
   initial begin
      i_ref_clk = 1'b0;
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end
   // Cut a hang short: the whole run needs well under 5000 cycles.
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         finish_test();
      end
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // Model of one local slot; global indices are never drawn, their mapping is internal.
   function automatic logic pool(int idx);
      if (idx < 48) return i_remote[idx-32];
      if (idx < 56) return (i_edge_region || idx < 52) ? i_regional[idx-48] : 1'b0;
      if (idx < 58) return i_local_fab[idx-56];
      return 1'b0;
   endfunction : pool
   task automatic chk(string what, logic [79:0] exp, logic [79:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic switch_all(logic [15:0] sel);
      i_mux_sel = sel;
      for (int n = 0; n < 300 && o_mux_active !== sel; n++) @(negedge i_ref_clk);
   endtask : switch_all
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   initial begin
      i_rst = 1'b1;
      {i_mux_sel, i_mux_en, i_remote, i_regional, i_edge_region} = '0;
      {i_local_sel, i_local_fab, i_if_fab, i_cell_ce, i_alt_pin} = '0;
      repeat (6) @(posedge i_ref_clk);
      @(negedge i_ref_clk) i_rst = 1'b0;
      chk("active after reset", 16'h0000, o_mux_active);
      i_mux_en = 8'hFF;
      for (int k = 0; k < 6; k++) begin
         switch_all(16'(xs()));
         chk("active input", i_mux_sel, o_mux_active);
      end
      {hi, lo} = 16'h0000;
      repeat (40) @(negedge i_ref_clk) {hi, lo} = {hi | o_mux_clk, lo | ~o_mux_clk};
      chk("all eight muxes toggle", 8'hFF, hi & lo);
      i_mux_en = 8'h00;
      repeat (10) @(negedge i_ref_clk);
      ex = o_mux_active;
      i_mux_sel = ~i_mux_sel;
      repeat (60) @(negedge i_ref_clk);
      chk("select while disabled", ex, o_mux_active);
      chk("disabled clocks", 8'h00, o_mux_clk);
      i_mux_en = 8'hFF;
      switch_all(i_mux_sel);
      chk("active after enable", i_mux_sel, o_mux_active);
      for (int k = 0; k < 24; k++) begin
         i_local_sel = {xs(), xs(), xs()};
         i_cell_ce = 80'(i_local_sel);
         i_local_sel = i_local_sel | {16{6'h20}};
         {i_remote, i_regional, i_local_fab, i_if_fab, i_edge_region, i_alt_pin} = 30'(xs());
         for (int s = 0; s < 16; s++) ex[s] = pool(int'(i_local_sel[6*s+:6]));
         #1;
         chk("synth reference", 1'b1 & i_alt_pin, o_synth_ref);
         // Pin inputs pass two sync flops and one output flop: three cycles.
         repeat (3) @(negedge i_ref_clk);
         chk("local low net", ex, o_local_lo);
         chk("local high net", ex, o_local_hi);
         chk("top bottom fabric", i_local_fab, o_if_tb[15:14]);
         chk("side interface", {i_local_fab, i_regional[1:0]}, o_if_side);
         chk("cell enables", i_cell_ce, o_cell_ce);
      end
      finish_test();
   end
endmodule : fabric_clock_selection_network_bench
`default_nettype wire

/* test/fcsn_monitor.sv */
// Port checker of the clock selection network, bound to its top.
// Assumes a single reference clock domain.
`timescale 1ns/10ps
`default_nettype none
module fcsn_monitor
   import fcsn_pkg::*;
#(parameter int CELLS = 80)(
   input wire logic                         i_ref_clk,
   input wire logic                         i_rst,
   input wire logic [NUM_DYN_MUX*SEL_W-1:0] i_mux_sel,
   input wire logic [NUM_DYN_MUX-1:0]       i_mux_en,
   input wire logic [NUM_DYN_MUX-1:0]       o_mux_clk,
   input wire logic [NUM_DYN_MUX*SEL_W-1:0] o_mux_active,
   input wire logic [LOCAL_MAX*6-1:0]       i_local_sel,
   input wire logic                         i_edge_region,
   input wire logic [1:0]                   i_local_fab,
   input wire logic [LOCAL_MAX-1:0]         o_local_lo,
   input wire logic [CELLS-1:0]             i_cell_ce,
   input wire logic [CELLS-1:0]             o_cell_ce,
   input wire logic [LOCAL_MAX-1:0]         o_if_tb,
   input wire logic [IF_SIDE_MAX-1:0]       o_if_side,
   input wire logic                         i_alt_pin,
   input wire logic                         o_synth_ref
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   AST_RST_SEL0: assert property ($fell(i_rst) |-> o_mux_active == '0)
      else $error("active input not zero after reset");
   AST_SWITCH: assert property (i_mux_en[0] && $stable(i_mux_sel[1:0])
      && o_mux_active[1:0] != i_mux_sel[1:0] |-> ##[1:150] (o_mux_active[1:0] == i_mux_sel[1:0]
      || !i_mux_en[0] || $changed(i_mux_sel[1:0]))) else $error("switch not done in time");
   AST_REFUSE: assert property ((!i_mux_en[0])[*4] |=> $stable(o_mux_active[1:0]))
      else $error("active input moved while disabled");
   AST_HANDOVER: assert property ($changed(o_mux_active[1:0]) |-> !o_mux_clk[0])
      else $error("handover with the output clock high");
   AST_GATE_OFF: assert property ((!i_mux_en[0])[*8] ##1 (!i_mux_en[0])[*4] |-> !o_mux_clk[0])
      else $error("disabled mux still drives its clock");
   AST_CE_LAT: assert property (!$past(i_rst, 1) && !$past(i_rst, 2) && !$past(i_rst, 3)
      |-> o_cell_ce == $past(i_cell_ce, 3)) else $error("cell enable latency wrong");
   AST_LOCAL_NONE: assert property ($past(i_local_sel[5:0], 3) >= 6'h3A |-> !o_local_lo[0])
      else $error("out of pool index not zero");
   AST_LOCAL_REG: assert property (!$past(i_edge_region, 3)
      && $past(i_local_sel[5:0], 3) inside {[6'h34:6'h37]}
      |-> !o_local_lo[0]) else $error("core region used a fifth regional line");
   AST_IF_FAB: assert property (!$past(i_rst, 1) && !$past(i_rst, 2) && !$past(i_rst, 3)
      |-> o_if_tb[15:14] == $past(i_local_fab, 3) && o_if_side[3:2] == $past(i_local_fab, 3))
      else $error("interface fabric clocks wrong");
   AST_ALT: assert property (o_synth_ref == i_alt_pin)
      else $error("alternate input not passed through");
endmodule : fcsn_monitor
bind fcsn_top fcsn_monitor #(.CELLS(CELLS)) fcsn_monitor_i (.i_ref_clk(i_ref_clk),
   .i_rst(i_rst), .i_mux_sel(i_mux_sel), .i_mux_en(i_mux_en), .o_mux_clk(o_mux_clk),
   .o_mux_active(o_mux_active), .i_local_sel(i_local_sel), .i_edge_region(i_edge_region),
   .i_local_fab(i_local_fab), .o_local_lo(o_local_lo), .i_cell_ce(i_cell_ce),
   .o_cell_ce(o_cell_ce), .o_if_tb(o_if_tb), .o_if_side(o_if_side), .i_alt_pin(i_alt_pin),
   .o_synth_ref(o_synth_ref));
`default_nettype wire

/* test/fcsn_user_model.sv */
// Far-side user logic: free-running candidate clocks for every mux input.
// Assumes the reference clock oversamples each source by at least 4x.
`timescale 1ns/10ps
`default_nettype none
module fcsn_user_clocks (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   output logic      [31:0] o_src
);
   // ==========================================================
   // Sources toggle from reset on, input 0 included, so both ends of a switch run.
   for (genvar g = 0; g < 32; g++) begin : g_src
      int   cnt;   // Reference cycles since the last toggle.
      logic clk;   // This source clock.
      always_ff @(negedge i_ref_clk or posedge i_rst) begin
         if (i_rst) begin
            cnt <= 0;
            clk <= 1'b0;
         end else if (cnt >= 2 + g % 4) begin
            cnt <= 0;
            clk <= ~clk;
         end else begin
            cnt <= cnt + 1;
         end
      end
      assign o_src[g] = clk;
   end
endmodule : fcsn_user_clocks
`default_nettype wire
